// ==== hdl/hs_pkg.sv ====
// hs_pkg: constants, types and the checksum function shared by the sensor bus target.
// Assumes a 40 MHz core clock and a two-wire bus clock of at most 1 MHz.
// Contract
// [R01] CRC-8, poly 0x31, init 0xFF, no reflection
// [R02] Checksums guard read and write data words
// [R03] Controller acks data, reads checksum byte too
// [R04] Separate signed offsets for humidity and temperature
// [R05] Every reset leaves the sensor asleep
// [R06] Measure request: convert, store, back to sleep
// [R07] Controller returns sensor to sleep first
// [R08] Results read once, then minimum codes
// [R09] Target only, address 0x44 to 0x47
// [R10] Bytes shifted most significant bit first
// [R11] Controller waits power-up ready interval
// [R12] Controller sends only defined command codes
// [R13] Controller follows config words with checksum
// [R14] Read command written before read transaction
// [R15] Checksum byte after every returned word
// [R16] Missing acknowledge stops further data bytes
// [R17] Controller clocks in final checksum byte
// [R18] Repeated START between command and read
// [R19] Results are 16-bit unsigned codes
// [R20] Checksum covers only preceding two bytes
// [R21] Automatic mode repeats at selectable rate
// [R22] Config word with bad checksum is dropped
package hs_pkg;

   // Core clock and automatic-mode time base
   localparam int CLK_PERIOD_NS = 25;
   localparam int AUTO_TICK_MS = 50;
   localparam int AUTO_TICK_CYC = AUTO_TICK_MS * 1000000 / CLK_PERIOD_NS;

   // Periods of automatic mode in base ticks
   localparam logic [7:0] AUTO_TICKS_OFF = 8'h00;
   localparam logic [7:0] AUTO_TICKS_2S = 8'h28;
   localparam logic [7:0] AUTO_TICKS_1S = 8'h14;
   localparam logic [7:0] AUTO_TICKS_2HZ = 8'h0A;
   localparam logic [7:0] AUTO_TICKS_4HZ = 8'h05;
   localparam logic [7:0] AUTO_TICKS_10HZ = 8'h02;

   // Checksum properties
   localparam logic [7:0] CRC_POLY = 8'h31;
   localparam logic [7:0] CRC_INIT = 8'hFF;
   localparam logic [7:0] CRC_XOROUT = 8'h00;

   // Target address, strap bits fill the two low bits
   localparam logic [6:0] TARGET_ADDR_BASE = 7'h44;

   // Values returned when nothing fresh or past the frame, and the offset loaded by hard reset
   localparam logic [15:0] RESULT_MIN = 16'h0000;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [15:0] OFS_RST = 16'h0000;

   // Command upper bytes
   localparam logic [7:0] CMD_TRIG_A = 8'h24;
   localparam logic [7:0] CMD_TRIG_B = 8'h2C;
   localparam logic [7:0] CMD_AUTO_2S = 8'h20;
   localparam logic [7:0] CMD_AUTO_1S = 8'h21;
   localparam logic [7:0] CMD_AUTO_2HZ = 8'h22;
   localparam logic [7:0] CMD_AUTO_4HZ = 8'h23;
   localparam logic [7:0] CMD_AUTO_10HZ = 8'h27;

   // Full command codes
   localparam logic [15:0] CMD_FETCH = 16'hE100;
   localparam logic [15:0] CMD_SOFT_RST = 16'h3000;
   localparam logic [15:0] CMD_OFS_T = 16'hA001;
   localparam logic [15:0] CMD_OFS_H = 16'hA002;

   // Write frame byte positions
   localparam logic [2:0] WR_CMD_HI = 3'h0;
   localparam logic [2:0] WR_CMD_LO = 3'h1;
   localparam logic [2:0] WR_CFG_HI = 3'h2;
   localparam logic [2:0] WR_CFG_LO = 3'h3;
   localparam logic [2:0] WR_CFG_CRC = 3'h4;
   localparam logic [2:0] WR_DONE = 3'h5;

   // Read frame length, two words each with checksum
   localparam logic [2:0] RD_LAST = 3'h5;

   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] hum;
   } hs_pair_s;

   typedef enum logic [3:0] {
      BUS_IDLE = 4'h1,
      BUS_ADDR = 4'h2,
      BUS_WRITE = 4'h4,
      BUS_READ = 4'h8
   } hs_bus_e;

   typedef enum logic [1:0] {
      MEAS_SLEEP = 2'h1,
      MEAS_RUN = 2'h2
   } hs_meas_e;

   // Checksum over one word, upper bit first
   function automatic logic [7:0] hs_crc8(input logic [15:0] word);
      logic [7:0] crc;
      logic fb;
      crc = CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         fb = crc[7] ^ word[i];
         crc = {crc[6:0], 1'h0} ^ (fb ? CRC_POLY : 8'h00); // R01
      end
      return crc ^ CRC_XOROUT;
   endfunction : hs_crc8

endpackage : hs_pkg

// ==== hdl/hs_ofs_sat.sv ====
// hs_ofs_sat: adds a signed offset to an unsigned result code, clamped to the code range.
// Assumes both inputs belong to the core clock domain; purely combinational.
`timescale 1ns/100ps
module hs_ofs_sat (
   input wire logic [15:0] code,
   input wire logic [15:0] ofs,
   output logic [15:0] result
);
   import hs_pkg::*;

   logic signed [17:0] sum;

   // Clamp instead of wrapping, so a large offset cannot flip hot to cold
   always_comb begin
      sum = $signed({2'h0, code}) + $signed({{2{ofs[15]}}, ofs});
      if (sum[17]) begin
         result = RESULT_MIN;
      end else if (sum[16]) begin
         result = 16'hFFFF;
      end else begin
         result = sum[15:0];
      end
   end

endmodule : hs_ofs_sat

// ==== hdl/hs_i2c_target.sv ====
// hs_i2c_target: two-wire bus target of the humidity and temperature sensor.
// Assumes conversion data and offsets arrive on the core clock; bus pins and straps are
// asynchronous. The bus clock also clocks a small shift register on the link side.
`timescale 1ns/100ps
module hs_i2c_target #(
   parameter int AUTO_TICK_CYCLES = hs_pkg::AUTO_TICK_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_clk,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic target_id_strap_high,
   input wire logic target_id_strap_low,
   output logic conv_req,
   input wire logic conv_done,
   input wire hs_pkg::hs_pair_s conv_raw,
   input wire hs_pkg::hs_pair_s nv_ofs,
   output hs_pkg::hs_pair_s ofs_now,
   output logic meas_mode
);
   import hs_pkg::*;

   // Link side: bits land here on the real bus clock rise
   logic [7:0] link_shift;
   logic [7:0] next_link_shift;

   always_comb begin
      next_link_shift = {link_shift[6:0], sda_i}; // R10
   end

   // Stable for a whole bus bit, core reads it after the synced rise
   always_ff @(posedge scl_clk) begin
      link_shift <= next_link_shift;
   end

   // Synchronisers and edge history
   logic [1:0] scl_sy, sda_sy, hi_sy, lo_sy;
   logic [1:0] next_scl_sy, next_sda_sy, next_hi_sy, next_lo_sy;
   logic scl_d, sda_d, next_scl_d, next_sda_d;

   always_comb begin
      next_scl_sy = {scl_sy[0], scl_clk};
      next_sda_sy = {sda_sy[0], sda_i};
      next_hi_sy = {hi_sy[0], target_id_strap_high};
      next_lo_sy = {lo_sy[0], target_id_strap_low};
      next_scl_d = scl_sy[1];
      next_sda_d = sda_sy[1];
   end

   // Idle bus is high on both wires
   always_ff @(posedge clk) begin
      if (rst) begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
         hi_sy <= 2'h0;
         lo_sy <= 2'h0;
         scl_d <= 1'h1;
         sda_d <= 1'h1;
      end else begin
         scl_sy <= next_scl_sy;
         sda_sy <= next_sda_sy;
         hi_sy <= next_hi_sy;
         lo_sy <= next_lo_sy;
         scl_d <= next_scl_d;
         sda_d <= next_sda_d;
      end
   end

   // Bus events, all from the second synchroniser stage onward
   logic scl_rise, scl_fall, start_ev, stop_ev;
   logic [6:0] my_addr;

   assign scl_rise = scl_sy[1] & ~scl_d;
   assign scl_fall = ~scl_sy[1] & scl_d;
   assign start_ev = scl_sy[1] & scl_d & sda_d & ~sda_sy[1];
   assign stop_ev = scl_sy[1] & scl_d & ~sda_d & sda_sy[1];
   assign my_addr = {TARGET_ADDR_BASE[6:2], hi_sy[1], lo_sy[1]}; // R09

   // Bus state
   hs_bus_e bus_st, next_bus_st;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic ack_pend, next_ack_pend;
   logic rw_rd, next_rw_rd;
   logic [2:0] wr_idx, next_wr_idx;
   logic [2:0] tx_idx, next_tx_idx;
   logic [15:0] cmd, next_cmd;
   logic [15:0] cfg, next_cfg;
   hs_pair_s snap, next_snap;
   logic next_oe;
   logic cmd_ev, next_cmd_ev;
   logic cfg_ev, next_cfg_ev;
   logic rd_ev, next_rd_ev;
   logic fresh;
   hs_pair_s result;
   logic [7:0] cur_byte;

   // Byte being returned: high byte, low byte, checksum, twice
   always_comb begin
      unique case (tx_idx)
         3'h0: cur_byte = snap.temp[15:8];
         3'h1: cur_byte = snap.temp[7:0];
         3'h2: cur_byte = hs_crc8(snap.temp); // R15 R20
         3'h3: cur_byte = snap.hum[15:8];
         3'h4: cur_byte = snap.hum[7:0];
         3'h5: cur_byte = hs_crc8(snap.hum); // R15 R20
         default: cur_byte = IDLE_BYTE;
      endcase
   end

   // Bus sequencing: address, write bytes, read bytes, acknowledge slots
   always_comb begin
      next_bus_st = bus_st;
      next_bit_cnt = bit_cnt;
      next_ack_pend = ack_pend;
      next_rw_rd = rw_rd;
      next_wr_idx = wr_idx;
      next_tx_idx = tx_idx;
      next_cmd = cmd;
      next_cfg = cfg;
      next_snap = snap;
      next_oe = sda_oe;
      next_cmd_ev = 1'h0;
      next_cfg_ev = 1'h0;
      next_rd_ev = 1'h0;
      if (start_ev) begin
         // Repeated START keeps the last command for the read that follows
         next_bus_st = BUS_ADDR; // R18
         next_bit_cnt = 4'h0;
         next_ack_pend = 1'h0;
         next_oe = 1'h0;
      end else if (stop_ev) begin
         next_bus_st = BUS_IDLE;
         next_oe = 1'h0;
      end else if (scl_rise && bus_st != BUS_IDLE) begin
         next_bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
         if (bit_cnt == 4'h7 && bus_st == BUS_ADDR) begin
            next_ack_pend = (link_shift[7:1] == my_addr); // R09
            next_rw_rd = link_shift[0];
         end else if (bit_cnt == 4'h7 && bus_st == BUS_WRITE) begin
            next_ack_pend = 1'h1;
            if (wr_idx != WR_DONE) begin
               next_wr_idx = wr_idx + 3'h1;
            end
            case (wr_idx)
               WR_CMD_HI: next_cmd[15:8] = link_shift;
               WR_CMD_LO: begin
                  next_cmd[7:0] = link_shift;
                  next_cmd_ev = 1'h1;
               end
               WR_CFG_HI: next_cfg[15:8] = link_shift;
               WR_CFG_LO: next_cfg[7:0] = link_shift;
               WR_CFG_CRC: next_cfg_ev = (hs_crc8(cfg) == link_shift); // R02 R13 R22
               default: next_cfg_ev = 1'h0;
            endcase
         end else if (bit_cnt == 4'h8) begin
            next_ack_pend = 1'h0;
            if (bus_st == BUS_ADDR) begin
               if (!ack_pend) begin
                  next_bus_st = BUS_IDLE;
               end else if (rw_rd) begin
                  // Take the results now; stale ones read as minimum codes
                  next_bus_st = BUS_READ;
                  next_tx_idx = 3'h0;
                  next_snap = fresh ? result : '{temp: RESULT_MIN, hum: RESULT_MIN}; // R08
                  next_rd_ev = 1'h1;
               end else begin
                  next_bus_st = BUS_WRITE;
                  next_wr_idx = WR_CMD_HI;
               end
            end else if (bus_st == BUS_READ) begin
               if (sda_sy[1]) begin
                  next_bus_st = BUS_IDLE; // R16
               end else if (tx_idx <= RD_LAST) begin
                  next_tx_idx = tx_idx + 3'h1;
               end
            end
         end
      end else if (scl_fall && bus_st != BUS_IDLE) begin
         // Drive only after the fall so the controller sees a clean setup
         if (bit_cnt == 4'h8) begin
            next_oe = ack_pend;
         end else if (bus_st == BUS_READ) begin
            next_oe = ~cur_byte[3'h7 - bit_cnt[2:0]]; // R10
         end else begin
            next_oe = 1'h0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_st <= BUS_IDLE;
         bit_cnt <= 4'h0;
         ack_pend <= 1'h0;
         rw_rd <= 1'h0;
         wr_idx <= WR_CMD_HI;
         tx_idx <= 3'h0;
         cmd <= 16'h0000;
         cfg <= 16'h0000;
         snap <= '{temp: RESULT_MIN, hum: RESULT_MIN};
         sda_oe <= 1'h0;
         sda_o <= 1'h0;
         cmd_ev <= 1'h0;
         cfg_ev <= 1'h0;
         rd_ev <= 1'h0;
      end else begin
         bus_st <= next_bus_st;
         bit_cnt <= next_bit_cnt;
         ack_pend <= next_ack_pend;
         rw_rd <= next_rw_rd;
         wr_idx <= next_wr_idx;
         tx_idx <= next_tx_idx;
         cmd <= next_cmd;
         cfg <= next_cfg;
         snap <= next_snap;
         sda_oe <= next_oe;
         sda_o <= 1'h0; // Open drain: only ever pulls low
         cmd_ev <= next_cmd_ev;
         cfg_ev <= next_cfg_ev;
         rd_ev <= next_rd_ev;
      end
   end

   // Offset correction, one instance per quantity
   hs_pair_s corr;

   hs_ofs_sat u_ofs_temp (
      .code(conv_raw.temp),
      .ofs(ofs_now.temp),
      .result(corr.temp)
   );

   hs_ofs_sat u_ofs_hum (
      .code(conv_raw.hum),
      .ofs(ofs_now.hum),
      .result(corr.hum)
   );

   // Measurement control state
   hs_meas_e meas_st, next_meas_st;
   logic [7:0] auto_per, next_auto_per;
   logic [31:0] tick_cnt, next_tick_cnt;
   logic [7:0] tick_num, next_tick_num;
   hs_pair_s next_result, next_ofs;
   logic next_fresh, next_conv_req, next_meas_mode;
   logic nv_loaded, next_nv_loaded;
   logic soft_rst, next_soft_rst;
   logic trig, auto_fire;

   // Commands, rate timer and the sleep/measure cycle
   always_comb begin
      next_meas_st = meas_st;
      next_auto_per = auto_per;
      next_tick_cnt = tick_cnt;
      next_tick_num = tick_num;
      next_result = result;
      next_ofs = ofs_now;
      next_fresh = fresh;
      next_conv_req = 1'h0;
      next_nv_loaded = 1'h1;
      next_soft_rst = 1'h0;
      trig = 1'h0;
      auto_fire = 1'h0;
      // Offsets come from the non-volatile store once after any reset
      if (!nv_loaded) begin
         next_ofs = nv_ofs; // R04
      end
      if (auto_per != AUTO_TICKS_OFF) begin
         if (tick_cnt == 32'(AUTO_TICK_CYCLES - 1)) begin
            next_tick_cnt = 32'h0;
            if (tick_num == auto_per - 8'h01) begin
               next_tick_num = 8'h00;
               auto_fire = 1'h1; // R21
            end else begin
               next_tick_num = tick_num + 8'h01;
            end
         end else begin
            next_tick_cnt = tick_cnt + 32'h1;
         end
      end
      if (cmd_ev) begin
         case (cmd[15:8])
            CMD_TRIG_A, CMD_TRIG_B: trig = 1'h1; // R06
            CMD_AUTO_2S: next_auto_per = AUTO_TICKS_2S; // R21
            CMD_AUTO_1S: next_auto_per = AUTO_TICKS_1S;
            CMD_AUTO_2HZ: next_auto_per = AUTO_TICKS_2HZ;
            CMD_AUTO_4HZ: next_auto_per = AUTO_TICKS_4HZ;
            CMD_AUTO_10HZ: next_auto_per = AUTO_TICKS_10HZ;
            default: next_soft_rst = (cmd == CMD_SOFT_RST); // R05
         endcase
         if (next_auto_per != auto_per) begin
            // New rate restarts the timer and measures at once
            next_tick_cnt = 32'h0;
            next_tick_num = 8'h00;
            trig = 1'h1;
         end
      end
      // Each offset has its own command, the other is untouched
      if (cfg_ev && cmd == CMD_OFS_T) begin
         next_ofs.temp = cfg; // R04 R22
      end
      if (cfg_ev && cmd == CMD_OFS_H) begin
         next_ofs.hum = cfg; // R04 R22
      end
      // A read takes the pair; a store in the same cycle wins
      if (rd_ev) begin
         next_fresh = 1'h0; // R08
      end
      unique case (meas_st)
         MEAS_SLEEP: begin
            if (trig || auto_fire) begin
               next_conv_req = 1'h1;
               next_meas_st = MEAS_RUN; // R06
            end
         end
         MEAS_RUN: begin
            if (conv_done) begin
               next_result = corr; // R19
               next_fresh = 1'h1;
               next_meas_st = MEAS_SLEEP; // R06
            end
         end
         default: next_meas_st = MEAS_SLEEP;
      endcase
      next_meas_mode = (next_meas_st == MEAS_RUN);
   end

   // Soft reset puts the measurement side back asleep like a hard one
   always_ff @(posedge clk) begin
      if (rst || soft_rst) begin
         meas_st <= MEAS_SLEEP; // R05
         auto_per <= AUTO_TICKS_OFF;
         tick_cnt <= 32'h0;
         tick_num <= 8'h00;
         result <= '{temp: RESULT_MIN, hum: RESULT_MIN};
         ofs_now <= rst ? {OFS_RST, OFS_RST} : nv_ofs; // Soft reset never shows zero offsets
         fresh <= 1'h0;
         conv_req <= 1'h0;
         meas_mode <= 1'h0;
         nv_loaded <= 1'h0;
         soft_rst <= 1'h0;
      end else begin
         meas_st <= next_meas_st;
         auto_per <= next_auto_per;
         tick_cnt <= next_tick_cnt;
         tick_num <= next_tick_num;
         result <= next_result;
         ofs_now <= next_ofs;
         fresh <= next_fresh;
         conv_req <= next_conv_req;
         meas_mode <= next_meas_mode;
         nv_loaded <= next_nv_loaded;
         soft_rst <= next_soft_rst;
      end
   end

endmodule : hs_i2c_target

// ==== test/hs_i2c_target_properties.sv ====
// Checker: port timing of the sensor bus target, core clock domain.
// Assumes bind onto hs_i2c_target; the bus clock is only sampled as data.
`timescale 1ns/100ps
module hs_i2c_target_properties (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_clk,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic target_id_strap_high,
   input wire logic target_id_strap_low,
   input wire logic conv_req,
   input wire logic conv_done,
   input wire hs_pkg::hs_pair_s conv_raw,
   input wire hs_pkg::hs_pair_s nv_ofs,
   input wire hs_pkg::hs_pair_s ofs_now,
   input wire logic meas_mode
);
   import hs_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Open drain: only a pull-low, never a high level
   chk_open_drain: assert property (sda_o == 1'b0)
      else $error("sda output not low");
   chk_req_pulse: assert property (conv_req |=> !conv_req)
      else $error("conv_req longer than one cycle");
   chk_req_mode: assert property (conv_req |-> ##[0:1] meas_mode)
      else $error("request without measurement mode");
   chk_done_sleep: assert property (meas_mode && conv_done && !conv_req |=> !meas_mode)
      else $error("no return to sleep");
   chk_mode_cause: assert property ($rose(meas_mode) |-> conv_req || $past(conv_req))
      else $error("measurement mode without request");
   // Reset check must run while reset is high
   chk_reset_sleep: assert property (disable iff (1'b0)
      rst |=> !meas_mode && !conv_req && !sda_oe)
      else $error("not asleep after reset");
   chk_ofs_load: assert property ($fell(rst) |-> ##[1:3] ofs_now == nv_ofs)
      else $error("offsets not loaded");
   // SDA pull-low starts only while the bus clock is low
   chk_oe_on_low: assert property ($rose(sda_oe) |-> !scl_clk)
      else $error("sda pulled while scl high");
   chk_ofs_apart: assert property ($changed(ofs_now.temp)
      |-> $stable(ofs_now.hum) || ofs_now == nv_ofs)
      else $error("offsets not independent");
endmodule : hs_i2c_target_properties

bind hs_i2c_target hs_i2c_target_properties i_hs_i2c_target_properties (
   .clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .target_id_strap_high(target_id_strap_high), .target_id_strap_low(target_id_strap_low),
   .conv_req(conv_req), .conv_done(conv_done), .conv_raw(conv_raw), .nv_ofs(nv_ofs),
   .ofs_now(ofs_now), .meas_mode(meas_mode));

// ==== test/hs_ctrl_model.sv ====
// Bus controller model: SCL generator and SDA pull-low, called as tasks.
// Assumes a pulled-up SDA wire resolved by the bench; SCL idles high between frames.
`timescale 1ns/100ps
module hs_ctrl_model (
   output logic scl,
   output logic pull,
   input wire logic sda
);
   // Quarter bit, just under the 1 MHz bus limit
   localparam time Q = 260ns;
   initial begin
      scl = 1'b1;
      pull = 1'b0;
   end
   // One bit: data set while SCL low, sampled at high
   task automatic bit_io(input logic b, output logic s);
      pull = !b;
      #Q scl = 1'b1;
      #Q s = sda;
      #Q scl = 1'b0;
      #Q;
   endtask : bit_io
   // Also serves as repeated START from SCL low
   task automatic start();
      pull = 1'b0;
      #Q scl = 1'b1;
      #(2 * Q) pull = 1'b1;
      #Q scl = 1'b0;
      #Q;
   endtask : start
   task automatic stop();
      pull = 1'b1;
      #Q scl = 1'b1;
      #Q pull = 1'b0;
      #Q;
   endtask : stop
   task automatic wr(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask : wr
   // Acknowledge set per byte by caller, checksum byte included
   task automatic rd(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(!ack, s);
   endtask : rd
endmodule : hs_ctrl_model

// ==== test/hs_i2c_target_bench.sv ====
// Bench: bus target driven by the controller model, converter modelled here.
// Assumes a shortened automatic-mode tick; SDA resolved as a pulled-up wire.
`timescale 1ns/100ps
module hs_i2c_target_bench;
   import hs_pkg::*;
   localparam int TICK = 20;
   logic clk = 1'b0, rst = 1'b1, conv_done = 1'b0, s_hi = 1'b0, s_lo = 1'b0;
   hs_pair_s conv_raw = 32'h1234_0008, nv_ofs = 32'h0010_FFF0, ofs_now;
   logic scl, pull, sda, sda_o, sda_oe, conv_req, meas_mode;
   int num_errors = 0, n_checks = 0, cyc = 0, last_t = 0, gap = 0, n_req = 0;
   // Wired-AND of both pull-lows over the pull-up
   assign sda = !(sda_oe === 1'b1 || pull === 1'b1);
   hs_i2c_target #(.AUTO_TICK_CYCLES(TICK)) i_hs_i2c_target (.clk(clk), .rst(rst),
      .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .target_id_strap_high(s_hi), .target_id_strap_low(s_lo), .conv_req(conv_req),
      .conv_done(conv_done), .conv_raw(conv_raw), .nv_ofs(nv_ofs), .ofs_now(ofs_now),
      .meas_mode(meas_mode));
   hs_ctrl_model i_hs_ctrl_model (.scl(scl), .pull(pull), .sda(sda));
   initial forever #12.5 clk = !clk;
   // Converter answers ten cycles after each request
   initial forever begin
      @(posedge clk);
      if (conv_req === 1'b1) begin
         repeat (10) @(negedge clk);
         conv_done = 1'b1;
         @(negedge clk) conv_done = 1'b0;
      end
   end
   // Request counter and spacing
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (conv_req === 1'b1) begin
         gap <= cyc - last_t;
         last_t <= cyc;
         n_req <= n_req + 1;
      end
   end
   function automatic logic [7:0] crc(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
      return c;
   endfunction : crc
   function automatic logic [15:0] sat(input logic [15:0] c, input logic [15:0] o);
      logic [16:0] s;
      s = {1'b0, c} + {o[15], o};
      return s[16] ? (o[15] ? 16'h0000 : 16'hFFFF) : s[15:0];
   endfunction : sat
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_frame(input logic [7:0] b[$], input bit do_stop);
      logic a;
      i_hs_ctrl_model.start();
      foreach (b[i]) begin
         i_hs_ctrl_model.wr(b[i], a);
         chk(a, 1'b1);
      end
      if (do_stop) i_hs_ctrl_model.stop();
      repeat (8) @(negedge clk);
   endtask : wr_frame
   task automatic rd_pair(input logic [15:0] t, input logic [15:0] h);
      logic a;
      logic [7:0] d[6];
      i_hs_ctrl_model.start();
      i_hs_ctrl_model.wr(8'h89, a);
      chk(a, 1'b1);
      for (int i = 0; i < 6; i++) i_hs_ctrl_model.rd(i < 5, d[i]);
      i_hs_ctrl_model.stop();
      chk({d[0], d[1]}, t);
      chk(d[2], crc(t));
      chk({d[3], d[4]}, h);
      chk(d[5], crc(h));
   endtask : rd_pair
   // Trigger, fetch with repeated START, then a stale read
   task automatic t_measure(input logic [7:0] trig, input logic [15:0] t,
                            input logic [15:0] h);
      int n0;
      n0 = n_req;
      wr_frame('{8'h88, trig, 8'h00}, 1'b1);
      chk(n_req - n0, 1);
      chk(meas_mode, 1'b0);
      wr_frame('{8'h88, 8'hE1, 8'h00}, 1'b0);
      rd_pair(t, h);
      wr_frame('{8'h88, 8'hE1, 8'h00}, 1'b0);
      rd_pair(RESULT_MIN, RESULT_MIN);
      $display("t_measure done");
   endtask : t_measure
   task automatic t_reset();
      chk(meas_mode, 1'b0);
      chk(sda_oe, 1'b0);
      chk(ofs_now, nv_ofs);
      chk(crc(16'hABCD), 8'h6F);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_addr();
      logic a;
      for (int k = 0; k < 4; k++) begin
         @(negedge clk) {s_hi, s_lo} = k[1:0];
         repeat (10) @(negedge clk);
         i_hs_ctrl_model.start();
         i_hs_ctrl_model.wr({5'h11, k[1:0], 1'b0}, a);
         chk(a, 1'b1);
         i_hs_ctrl_model.start();
         i_hs_ctrl_model.wr({5'h11, ~k[1:0], 1'b0}, a);
         chk(a, 1'b0);
         i_hs_ctrl_model.stop();
      end
      @(negedge clk) {s_hi, s_lo} = 2'h0;
      repeat (10) @(negedge clk);
      $display("t_addr done");
   endtask : t_addr
   // Good word on temperature, corrupted word on humidity
   task automatic t_ofs();
      chk(meas_mode, 1'b0);
      wr_frame('{8'h88, 8'hA0, 8'h01, 8'h00, 8'h40, crc(16'h0040)}, 1'b1);
      chk(ofs_now.temp, 16'h0040);
      chk(ofs_now.hum, nv_ofs.hum);
      wr_frame('{8'h88, 8'hA0, 8'h02, 8'h00, 8'h05, ~crc(16'h0005)}, 1'b1);
      chk(ofs_now.hum, nv_ofs.hum);
      t_measure(8'h2C, sat(16'h1234, 16'h0040), sat(16'h0008, nv_ofs.hum));
      $display("t_ofs done");
   endtask : t_ofs
   // NACK once the first checksum is in, later bytes find SDA released
   task automatic t_nack();
      logic a;
      logic [7:0] d[4];
      wr_frame('{8'h88, 8'hE1, 8'h00}, 1'b0);
      i_hs_ctrl_model.start();
      i_hs_ctrl_model.wr(8'h89, a);
      chk(a, 1'b1);
      for (int i = 0; i < 4; i++) i_hs_ctrl_model.rd(i < 2, d[i]);
      i_hs_ctrl_model.stop();
      chk({d[0], d[1]}, RESULT_MIN);
      chk(d[2], crc(RESULT_MIN));
      chk(d[3], IDLE_BYTE);
      $display("t_nack done");
   endtask : t_nack
   // Every rate, spacing between automatic requests, then soft reset
   task automatic t_auto();
      logic [7:0] cmd[5] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h27};
      int per[5] = '{40, 20, 10, 5, 2};
      int n0, w;
      for (int i = 0; i < 5; i++) begin
         wr_frame('{8'h88, cmd[i], 8'hFF}, 1'b1);
         n0 = n_req;
         w = 0;
         while (n_req < n0 + 2 && w < 4 * TICK * per[i] + 100) begin
            @(negedge clk);
            w++;
         end
         chk(gap, TICK * per[i]);
         wr_frame('{8'h88, 8'h30, 8'h00}, 1'b1);
         n0 = n_req;
         repeat (TICK * 90) @(negedge clk);
         chk(n_req - n0, 0);
         chk(meas_mode, 1'b0);
      end
      chk(ofs_now, nv_ofs);
      $display("t_auto done");
   endtask : t_auto
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   initial begin
      #2ms;
      num_errors++;
      give_verdict();
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      // Short stand-in for power_up_ready_interval
      repeat (40) @(negedge clk);
      t_reset();
      t_addr();
      t_measure(8'h24, sat(16'h1234, nv_ofs.temp), sat(16'h0008, nv_ofs.hum));
      t_ofs();
      t_nack();
      t_auto();
      give_verdict();
   end
endmodule : hs_i2c_target_bench
